// ===== src/can_bit_timing_error_detect.v
// Purpose: bit timing registers and can protocol error detection
// Assumes: frame logic on ref_clk gives field position and driven level
// Notes: registers reached over axi4-lite, one byte per aligned word
`default_nettype none
`include "can_timing_defines.vh"
module can_bit_timing_error_detect (
  input wire ref_clk,
  input wire reset,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire can_rx,
  input wire [3:0] frame_field,
  input wire transmitting,
  input wire tx_level,
  input wire hard_sync,
  output wire sample_point,
  output wire bit_start,
  output wire quantum_tick,
  output reg rx_bit,
  output reg stuff_bit,
  output reg [14:0] crc_value,
  output reg error_frame_start,
  output reg retransmit_request,
  output reg [4:0] error_event,
  output reg [2:0] sync_jump_quanta,
  output reg [3:0] phase_two_quanta,
  output reg wake_filter_enable,
  output reg config_mode,
  output wire irq
);
  reg [7:0] quantum_jump_config;
  reg [7:0] segment_timing_config;
  reg [7:0] phase_two_wake_config;
  reg [4:0] error_status;
  reg [4:0] error_enable;
  reg aw_held;
  reg [7:0] aw_addr;
  reg w_held;
  reg [7:0] w_data;
  reg w_lane;
  reg rx_meta;
  reg rx_sync;
  reg last_bit;
  reg [2:0] run_count;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;
  reg [3:0] next_phase_two;
  reg [4:0] next_event;
  reg next_stuff;
  wire [7:0] w_index;
  wire [7:0] r_index;
  wire do_write;
  wire [4:0] clear_hits;
  wire [3:0] prop_quanta;
  wire [3:0] phase_one_quanta;
  wire [14:0] crc_base;
  wire [14:0] crc_step;
  wire in_stuff_zone;
  wire feed_crc;

  // bus handshake
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign w_index = {2'b00, aw_addr[7:2]};
  assign r_index = {2'b00, s_axi_araddr[7:2]};

  always @(posedge ref_clk) begin
    if (reset) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 8'h00;
      w_lane <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (w_index)
          `IDX_PHASE_TWO_WAKE, `IDX_SEGMENT_TIMING, `IDX_QUANTUM_JUMP,
          `IDX_MODE_CONTROL, `IDX_ERROR_CLEAR, `IDX_ERROR_ENABLE: begin
            s_axi_bresp <= `RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes
  always @(posedge ref_clk) begin
    if (reset) begin
      quantum_jump_config <= `TIMING_RESET;
      segment_timing_config <= `TIMING_RESET;
      phase_two_wake_config <= `TIMING_RESET;
      config_mode <= `MODE_RESET;
      error_enable <= 5'h00;
    end else if (do_write && w_lane) begin
      case (w_index)
        `IDX_QUANTUM_JUMP: begin
          if (config_mode) begin
            quantum_jump_config <= w_data;
          end
        end
        `IDX_SEGMENT_TIMING: begin
          if (config_mode) begin
            segment_timing_config <= w_data;
          end
        end
        `IDX_PHASE_TWO_WAKE: begin
          if (config_mode) begin
            phase_two_wake_config <= w_data & `PHASE_TWO_WAKE_MASK;
          end
        end
        `IDX_MODE_CONTROL: begin
          config_mode <= w_data[0];
        end
        `IDX_ERROR_ENABLE: begin
          error_enable <= w_data[4:0];
        end
        default: begin
          config_mode <= config_mode;
        end
      endcase
    end
  end

  assign clear_hits = (do_write && w_lane && (w_index == `IDX_ERROR_CLEAR)) ?
                      w_data[4:0] : 5'h00;

  // read mux
  always @* begin
    next_rdata = 32'h00000000;
    next_rresp = `RESP_OKAY;
    case (r_index)
      `IDX_QUANTUM_JUMP: begin
        next_rdata = {24'h000000, quantum_jump_config};
      end
      `IDX_SEGMENT_TIMING: begin
        next_rdata = {24'h000000, segment_timing_config};
      end
      `IDX_PHASE_TWO_WAKE: begin
        next_rdata = {24'h000000, phase_two_wake_config};
      end
      `IDX_MODE_CONTROL: begin
        next_rdata = {31'h00000000, config_mode};
      end
      `IDX_ERROR_STATUS: begin
        next_rdata = {27'h0000000, error_status};
      end
      `IDX_ERROR_CLEAR: begin
        next_rdata = 32'h00000000;
      end
      `IDX_ERROR_ENABLE: begin
        next_rdata = {27'h0000000, error_enable};
      end
      `IDX_TIMING_STATUS: begin
        next_rdata = {25'h0000000, sync_jump_quanta, phase_two_quanta};
      end
      default: begin
        next_rresp = `RESP_SLVERR;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // derived timing
  assign prop_quanta = {1'b0, segment_timing_config[2:0]} + 4'h1;
  assign phase_one_quanta = {1'b0, segment_timing_config[5:3]} + 4'h1;

  always @* begin
    if (segment_timing_config[`SOURCE_SELECT_BIT]) begin
      next_phase_two = {1'b0, phase_two_wake_config[2:0]} + 4'h1;
    end else if (phase_one_quanta > `PROCESSING_QUANTA) begin
      next_phase_two = phase_one_quanta;
    end else begin
      next_phase_two = `PROCESSING_QUANTA;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      phase_two_quanta <= 4'h1;
      sync_jump_quanta <= 3'h1;
      wake_filter_enable <= 1'b0;
    end else begin
      phase_two_quanta <= next_phase_two;
      sync_jump_quanta <= {1'b0, quantum_jump_config[7:6]} + 3'h1;
      wake_filter_enable <= phase_two_wake_config[`WAKE_FILTER_BIT];
    end
  end

  can_bit_clock bit_clock (
    .ref_clk(ref_clk),
    .reset(reset),
    .prescale(quantum_jump_config[5:0]),
    .prop_quanta(prop_quanta),
    .phase_one_quanta(phase_one_quanta),
    .phase_two_quanta(phase_two_quanta),
    .hard_sync(hard_sync),
    .quantum_tick(quantum_tick),
    .sample_point(sample_point),
    .bit_start(bit_start)
  );

  // receive pin synchroniser
  always @(posedge ref_clk) begin
    if (reset) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= can_rx;
      rx_sync <= rx_meta;
    end
  end

  // error checks at each sample point
  assign in_stuff_zone = (frame_field == `FIELD_SOF) || (frame_field == `FIELD_ARB) ||
                         (frame_field == `FIELD_DATA) || (frame_field == `FIELD_CRC_SEQ);
  assign crc_base = (frame_field == `FIELD_SOF) ? 15'h0000 : crc_value;
  assign feed_crc = !next_stuff && ((frame_field == `FIELD_SOF) ||
                    (frame_field == `FIELD_ARB) || (frame_field == `FIELD_DATA) ||
                    ((frame_field == `FIELD_CRC_SEQ) && !transmitting));

  can_crc_step crc_step_unit (
    .crc_in(crc_base),
    .bit_in(rx_sync),
    .crc_out(crc_step)
  );

  always @* begin
    next_event = 5'h00;
    next_stuff = in_stuff_zone && (frame_field != `FIELD_SOF) &&
                 (run_count == `STUFF_RUN_LIMIT);
    if (next_stuff && (rx_sync == last_bit)) begin
      next_event[`ERR_STUFF] = 1'b1;
    end
    if ((frame_field == `FIELD_CRC_DELIM) && !transmitting && (crc_value != 15'h0000)) begin
      next_event[`ERR_CRC] = 1'b1;
    end
    if (transmitting && (frame_field == `FIELD_ACK_SLOT) && rx_sync) begin
      next_event[`ERR_ACK] = 1'b1;
    end
    if (!rx_sync && ((frame_field == `FIELD_CRC_DELIM) ||
        (frame_field == `FIELD_ACK_DELIM) || (frame_field == `FIELD_EOF) ||
        (frame_field == `FIELD_IFS))) begin
      next_event[`ERR_FORM] = 1'b1;
    end
    if (transmitting && (frame_field != `FIELD_IDLE) && (rx_sync != tx_level) &&
        !(tx_level && ((frame_field == `FIELD_ARB) ||
        (frame_field == `FIELD_ACK_SLOT)))) begin
      next_event[`ERR_BIT] = 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      rx_bit <= 1'b1;
      stuff_bit <= 1'b0;
      last_bit <= 1'b1;
      run_count <= 3'h0;
      crc_value <= 15'h0000;
      error_event <= 5'h00;
      error_frame_start <= 1'b0;
      retransmit_request <= 1'b0;
    end else if (sample_point) begin
      rx_bit <= rx_sync;
      stuff_bit <= next_stuff;
      last_bit <= rx_sync;
      if (!in_stuff_zone || (frame_field == `FIELD_SOF) || next_stuff ||
          (rx_sync != last_bit)) begin
        run_count <= in_stuff_zone ? 3'h1 : 3'h0;
      end else begin
        run_count <= run_count + 3'h1;
      end
      if (feed_crc) begin
        crc_value <= crc_step;
      end
      error_event <= next_event;
      error_frame_start <= |next_event;
      retransmit_request <= transmitting && (next_event[`ERR_ACK] ||
        next_event[`ERR_CRC] || next_event[`ERR_FORM] || next_event[`ERR_STUFF] ||
        next_event[`ERR_BIT]);
    end else begin
      error_event <= 5'h00;
      error_frame_start <= 1'b0;
      retransmit_request <= 1'b0;
    end
  end

  // sticky status, set wins over clear
  always @(posedge ref_clk) begin
    if (reset) begin
      error_status <= 5'h00;
    end else begin
      error_status <= (error_status & ~clear_hits) | error_event;
    end
  end

  assign irq = |(error_status & error_enable);

endmodule // can_bit_timing_error_detect
`default_nettype wire

// ===== src/can_timing_defines.vh
// Purpose: constants of the can bit timing and error detection block
// Assumes: included by its bare name
// Notes: register byte address is four times the register index
`ifndef CAN_TIMING_DEFINES_VH
`define CAN_TIMING_DEFINES_VH
`define IDX_PHASE_TWO_WAKE 8'h28
`define IDX_SEGMENT_TIMING 8'h29
`define IDX_QUANTUM_JUMP 8'h2a
`define IDX_MODE_CONTROL 8'h2b
`define IDX_ERROR_STATUS 8'h2c
`define IDX_ERROR_CLEAR 8'h2d
`define IDX_ERROR_ENABLE 8'h2e
`define IDX_TIMING_STATUS 8'h2f
`define TIMING_RESET 8'h00
`define MODE_RESET 1'b1
`define PHASE_TWO_WAKE_MASK 8'h47
`define WAKE_FILTER_BIT 6
`define SOURCE_SELECT_BIT 7
`define PROCESSING_QUANTA 4'h2
`define STUFF_RUN_LIMIT 3'h5
`define CRC_POLY 15'h4599
`define ERR_CRC 0
`define ERR_ACK 1
`define ERR_FORM 2
`define ERR_BIT 3
`define ERR_STUFF 4
`define FIELD_IDLE 4'h0
`define FIELD_SOF 4'h1
`define FIELD_ARB 4'h2
`define FIELD_DATA 4'h3
`define FIELD_CRC_SEQ 4'h4
`define FIELD_CRC_DELIM 4'h5
`define FIELD_ACK_SLOT 4'h6
`define FIELD_ACK_DELIM 4'h7
`define FIELD_EOF 4'h8
`define FIELD_IFS 4'h9
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== src/can_crc_step.v
// Purpose: one step of the 15-bit can check sequence
// Assumes: caller registers the result
// Notes: shifting the received check bits through leaves zero on a match
`default_nettype none
`include "can_timing_defines.vh"
module can_crc_step (
  input wire [14:0] crc_in,
  input wire bit_in,
  output wire [14:0] crc_out
);
  wire feedback;
  assign feedback = bit_in ^ crc_in[14];
  assign crc_out = {crc_in[13:0], 1'b0} ^ (feedback ? `CRC_POLY : 15'h0000);
endmodule // can_crc_step
`default_nettype wire

// ===== src/can_bit_clock.v
// Purpose: time quantum prescaler and bit segment counter
// Assumes: segment lengths given in quanta, each at least one
// Notes: hard_sync restarts the bit at its sync segment
`default_nettype none
module can_bit_clock (
  input wire ref_clk,
  input wire reset,
  input wire [5:0] prescale,
  input wire [3:0] prop_quanta,
  input wire [3:0] phase_one_quanta,
  input wire [3:0] phase_two_quanta,
  input wire hard_sync,
  output reg quantum_tick,
  output reg sample_point,
  output reg bit_start
);
  reg [6:0] div_count;
  reg [4:0] quanta;
  wire [6:0] div_limit;
  wire [4:0] seg_one_end;
  wire [4:0] bit_end;
  wire tick;
  assign div_limit = {prescale, 1'b1};
  assign tick = (div_count == div_limit);
  assign seg_one_end = {1'b0, prop_quanta} + {1'b0, phase_one_quanta};
  assign bit_end = seg_one_end + {1'b0, phase_two_quanta};
  always @(posedge ref_clk) begin
    if (reset) begin
      div_count <= 7'h00;
      quanta <= 5'h00;
      quantum_tick <= 1'b0;
      sample_point <= 1'b0;
      bit_start <= 1'b0;
    end else if (hard_sync) begin
      div_count <= 7'h00;
      quanta <= 5'h00;
      quantum_tick <= 1'b0;
      sample_point <= 1'b0;
      bit_start <= 1'b1;
    end else begin
      div_count <= tick ? 7'h00 : div_count + 7'h01;
      quantum_tick <= tick;
      sample_point <= tick && (quanta == seg_one_end);
      bit_start <= tick && (quanta == bit_end);
      if (tick) begin
        quanta <= (quanta == bit_end) ? 5'h00 : quanta + 5'h01;
      end
    end
  end
endmodule // can_bit_clock
`default_nettype wire

// ===== bench/can_peer.sv
// Purpose: the other nodes sharing the can bus
// Assumes: wired-and bus, 1 is recessive
// Notes: acknowledges a frame only while ack_on is high
`default_nettype none
module can_peer (
  input wire logic transmitting,
  input wire logic tx_level,
  input wire logic [3:0] frame_field,
  input wire logic peer_level,
  input wire logic ack_on,
  output logic can_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ack;
  // a receiving peer drives the ack slot dominant
  assign ack = ack_on && transmitting && frame_field == 4'h6;
  assign can_rx = (tx_level | !transmitting) & peer_level & !ack;
endmodule // can_peer
`default_nettype wire

// ===== bench/can_timing_chk.sv
// Purpose: error flag checks at the block ports
// Assumes: flags follow their sample point by one cycle
// Notes: bound at the foot of this file
`default_nettype none
module can_timing_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sample_point,
  input wire logic [3:0] frame_field,
  input wire logic transmitting,
  input wire logic [4:0] error_event,
  input wire logic error_frame_start,
  input wire logic retransmit_request,
  input wire logic rx_bit,
  input wire logic stuff_bit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_frame;
    error_frame_start == (error_event != 5'h0);
  endproperty
  a_frame: assert property (p_frame) else $error("error frame start mismatch");
  property p_at_sample;
    error_event != 5'h0 |-> $past(sample_point);
  endproperty
  a_at_sample: assert property (p_at_sample) else $error("error off sample point");
  property p_ack;
    error_event[1] |-> $past(transmitting) && $past(frame_field) == 4'h6;
  endproperty
  a_ack: assert property (p_ack) else $error("ack error out of place");
  property p_form;
    error_event[2] |-> $past(frame_field) inside {4'h5, 4'h7, 4'h8, 4'h9};
  endproperty
  a_form: assert property (p_form) else $error("form error out of place");
  property p_crc;
    error_event[0] |-> !$past(transmitting) && $past(frame_field) == 4'h5;
  endproperty
  a_crc: assert property (p_crc) else $error("crc error out of place");
  property p_bit;
    error_event[3] |-> $past(transmitting) && $past(frame_field) != 4'h0;
  endproperty
  a_bit: assert property (p_bit) else $error("bit error while receiving");
  property p_stuff;
    error_event[4] |-> $past(frame_field) inside {[4'h1:4'h4]};
  endproperty
  a_stuff: assert property (p_stuff) else $error("stuff error out of place");
  property p_retx;
    $past(transmitting) && error_event != 5'h0 |-> retransmit_request;
  endproperty
  a_retx: assert property (p_retx) else $error("no retransmit request");
  property p_stuff_bit;
    error_event[4] |-> stuff_bit;
  endproperty
  a_stuff_bit: assert property (p_stuff_bit) else $error("stuff error off a stuff bit");
  property p_ack_level;
    error_event[1] |-> rx_bit;
  endproperty
  a_ack_level: assert property (p_ack_level) else $error("ack error on dominant slot");
  c_stuff: cover property (error_event[4]);
  c_crc: cover property (error_event[0]);
  c_retx: cover property (retransmit_request);
endmodule // can_timing_chk
bind can_bit_timing_error_detect can_timing_chk chk (.ref_clk(ref_clk), .reset(reset),
  .sample_point(sample_point), .frame_field(frame_field), .transmitting(transmitting),
  .error_event(error_event), .error_frame_start(error_frame_start),
  .retransmit_request(retransmit_request), .rx_bit(rx_bit), .stuff_bit(stuff_bit));
`default_nettype wire

// ===== bench/testbench.sv
// Purpose: self-checking bench for can timing and error detection
// Assumes: peer model forms the bus level
// Notes: each bit is driven at bit start and judged after its sample point
`default_nettype none
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin num_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, x); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, reset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, can_rx;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire sample_point, bit_start, quantum_tick, error_frame_start, retransmit_request;
  wire wake_filter_enable, config_mode, irq;
  wire [14:0] crc_value;
  wire [4:0] error_event;
  wire [2:0] sync_jump_quanta;
  wire [3:0] phase_two_quanta;
  logic [3:0] frame_field = 4'h0;
  logic transmitting = 1'b0, tx_level = 1'b1, hard_sync = 1'b0, peer_level = 1'b1;
  logic ack_on = 1'b1, last, sp_q = 1'b0;
  int num_errors = 0, checks = 0, k, n, run;
  logic [5:0] evq[$];
  logic [33:0] rq[$];
  logic [1:0] wq[$];
  logic [5:0] p;
  logic [14:0] crc;
  can_bit_timing_error_detect dut (
    .ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .can_rx, .frame_field, .transmitting, .tx_level, .hard_sync, .sample_point, .bit_start,
    .quantum_tick, .rx_bit(), .stuff_bit(), .crc_value, .error_frame_start,
    .retransmit_request, .error_event, .sync_jump_quanta, .phase_two_quanta,
    .wake_filter_enable, .config_mode, .irq
  );
  can_peer peer (.transmitting, .tx_level, .frame_field, .peer_level, .ack_on, .can_rx);
  always #2.5 ref_clk = ~ref_clk;
  task automatic conclude;
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // results are taken off the queues as they appear
  always @(posedge ref_clk) begin
    logic [5:0] e;
    logic [33:0] r;
    logic [1:0] b;
    sp_q <= sample_point;
    if (sp_q && evq.size() > 0) begin
      e = evq.pop_front();
      `CHK({retransmit_request, error_event}, e)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      r = rq.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, r)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      b = wq.pop_front();
      `CHK(s_axi_bresp, b)
    end
  end
  task automatic await(input int s);
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge ref_clk);
      if ((s == 0 && bit_start) || (s == 1 && sample_point) || (s == 2 && quantum_tick))
        return;
    end
    num_errors++;
    conclude();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] x);
    int i;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    wq.push_back(x);
    for (i = 0; i < 100 && !s_axi_bvalid; i++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (i == 100) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] x);
    int i;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rq.push_back(x);
    for (i = 0; i < 100 && !s_axi_rvalid; i++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (i == 100) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic bit_out(input logic [3:0] f, input logic t, input logic tl, input logic pl,
      input logic [5:0] e);
    await(0);
    frame_field <= f;
    transmitting <= t;
    tx_level <= tl;
    peer_level <= pl;
    evq.push_back(e);
    await(1);
    @(posedge ref_clk);
  endtask
  task automatic row(input logic t, input logic [3:0] f, input logic tl, input logic pl,
      input logic a, input logic [5:0] e);
    ack_on <= a;
    bit_out(4'h1, t, 1'b0, 1'b0, 6'h0);
    bit_out(f, t, tl, pl, e);
    bit_out(4'h0, 1'b0, 1'b1, 1'b1, 6'h0);
  endtask
  // received bit with stuffing and check sequence kept by the bench
  task automatic sbit(input logic [3:0] f, input logic b, input logic [5:0] e);
    if (run == 5) begin
      bit_out(f > 4'h4 ? 4'h4 : f, 1'b0, 1'b1, !last, 6'h0);
      last = !last;
      run = 1;
    end
    bit_out(f, 1'b0, 1'b1, b, e);
    run = (b == last) ? run + 1 : 1;
    last = b;
    if (f < 4'h4) crc = {crc[13:0], 1'b0} ^ ((b ^ crc[14]) ? 15'h4599 : 15'h0);
  endtask
  task automatic rx_frame(input logic bad, input logic delim);
    logic [14:0] c;
    int i;
    crc = 15'h0;
    last = 1'b1;
    run = 0;
    sbit(4'h1, 1'b0, 6'h0);
    sbit(4'h2, 1'b1, 6'h0);
    for (i = 0; i < 18; i++) sbit(i < 10 ? 4'h2 : 4'h3, 1'($urandom), 6'h0);
    `CHK(crc_value, crc)
    c = crc ^ {14'h0, bad};
    for (i = 14; i >= 0; i--) sbit(4'h4, c[i], 6'h0);
    sbit(4'h5, delim, {3'b000, !delim, 1'b0, bad});
    bit_out(4'h0, 1'b0, 1'b1, 1'b1, 6'h0);
  endtask
  initial begin
    n = $urandom(88);
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    for (k = 0; k < 3; k++) rd(8'ha0 + 8'(4 * k), 34'h0);
    rd(8'hbc, {2'h0, 32'h12});
    rd(8'hac, {2'h0, 32'h1});
    rd(8'h10, {2'h2, 32'h0});
    for (k = 0; k < 4; k++) begin
      p = 6'($urandom);
      wr(8'ha8, {k[1:0], p}, 2'h0);
      @(posedge ref_clk);
      `CHK(sync_jump_quanta, 3'(k + 1))
      await(2);
      await(2);
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (!quantum_tick && n < 200);
      `CHK(n, 2 * (p + 1))
    end
    wr(8'ha8, 8'h00, 2'h0);
    wr(8'ha0, 8'hff, 2'h0);
    rd(8'ha0, {2'h0, 32'h47});
    `CHK(wake_filter_enable, 1'b1)
    wr(8'ha4, 8'h80, 2'h0);
    @(posedge ref_clk);
    `CHK(phase_two_quanta, 4'h8)
    wr(8'ha4, 8'h18, 2'h0);
    @(posedge ref_clk);
    `CHK(phase_two_quanta, 4'h4)
    rd(8'hbc, {2'h0, 32'h14});
    wr(8'hac, 8'h00, 2'h0);
    wr(8'ha8, 8'hff, 2'h0);
    rd(8'ha8, 34'h0);
    `CHK(config_mode, 1'b0)
    hard_sync <= 1'b1;
    @(posedge ref_clk);
    hard_sync <= 1'b0;
    await(0);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!bit_start && n < 100);
    `CHK(n, 20)
    row(1'b1, 4'h6, 1'b1, 1'b1, 1'b0, 6'h22);
    row(1'b1, 4'h6, 1'b1, 1'b1, 1'b1, 6'h00);
    row(1'b1, 4'h2, 1'b1, 1'b0, 1'b1, 6'h00);
    row(1'b1, 4'h3, 1'b1, 1'b0, 1'b1, 6'h28);
    for (k = 7; k < 10; k++) row(1'b0, 4'(k), 1'b1, 1'b0, 1'b1, 6'h04);
    bit_out(4'h1, 1'b1, 1'b0, 1'b0, 6'h0);
    for (k = 0; k < 6; k++) bit_out(4'h2, 1'b1, 1'b1, 1'b1, k == 5 ? 6'h30 : 6'h0);
    bit_out(4'h0, 1'b0, 1'b1, 1'b1, 6'h0);
    rx_frame(1'b0, 1'b0);
    rx_frame(1'b1, 1'b1);
    `CHK(irq, 1'b0)
    rd(8'hb0, {2'h0, 32'h1f});
    wr(8'hb8, 8'h02, 2'h0);
    `CHK(irq, 1'b1)
    wr(8'hb4, 8'h02, 2'h0);
    `CHK(irq, 1'b0)
    rd(8'hb0, {2'h0, 32'h1d});
    wr(8'hb0, 8'h00, 2'h2);
    rd(8'hb4, 34'h0);
    rd(8'hb8, {2'h0, 32'h02});
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rd(8'ha4, 34'h0);
    rd(8'hbc, {2'h0, 32'h12});
    conclude();
  end
endmodule // testbench
`default_nettype wire
